// >>> pmc_pkg.sv
// pmc_pkg: constants, field layout and types for the proximity measurement configuration block.
// assumes a single 125 MHz clock and a 32-bit AHB-Lite register bus.
package pmc_pkg;

	localparam int CLK_MHZ = 125;
	localparam int US_PER_MS = 1000;

	// register index as printed, byte address is four times it
	localparam logic [5:0] CFG_IDX = 6'h01;
	localparam logic [5:0] CTRL_IDX = 6'h04;
	localparam logic [5:0] RESULT_IDX = 6'h05;
	localparam logic [5:0] STATUS_IDX = 6'h06;

	localparam logic [15:0] CFG_RESET = 16'h0000;
	// bits 15:14 and 11 are reserved and kept at zero
	localparam logic [15:0] CFG_WRITE_MASK = 16'h37ff;

	localparam int CTRL_RUN_BIT = 0;
	localparam int CTRL_WIDE_BIT = 1;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_NEW_BIT = 1;

	// measurement period in ms for code 2, other codes are module parameters
	localparam int PERIOD_C2_MS = 200;
	localparam logic [1:0] PERIOD_C2_CODE = 2'h2;

	// base pulse length in us
	localparam int BASE_SHORT_US = 25;
	localparam int BASE_LONG_US = 50;

	localparam logic [15:0] NARROW_MAX = 16'h0fff;
	localparam logic [16:0] WIDE_SPAN_BASE = 17'h01000;

	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic HRESP_OKAY = 1'b0;

	typedef struct packed {
		logic [1:0] rsv_hi;
		logic converter_sensitivity;
		logic crosstalk_cancel_enable;
		logic rsv_mid;
		logic [2:0] emitter_drive_level;
		logic [1:0] repeat_period;
		logic [1:0] integration_multiplier;
		logic [1:0] pulse_count;
		logic base_pulse_length;
		logic converter_gain;
	} pmc_cfg_type;

	typedef struct packed {
		logic wide_resolution_select;
		logic run_enable;
	} pmc_ctrl_type;

	// highest result count for the active resolution, gain and integration
	function automatic logic [15:0] pmc_max_count(input logic wide, input logic gain,
			input logic [1:0] it);
		logic [16:0] span;
		// three bits so that multiplier 3 with gain two reaches the full 16-bit span
		span = WIDE_SPAN_BASE << (3'(it) + 3'(gain));
		if (!wide) begin
			return NARROW_MAX;
		end
		return 16'(span - 17'h00001);
	endfunction

endpackage

// >>> pmc_seq.sv
// pmc_seq: fires the emitter pulses of one measurement and strobes each sample.
// assumes start_i is a one-cycle pulse given only while busy_o is low.
`timescale 1ns/1ns
module pmc_seq
	import pmc_pkg::*;
(
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic start_i,
	input wire logic [31:0] slot_cycles_i,
	input wire logic [1:0] pulse_code_i,
	output logic busy_o,
	output logic emit_o,
	output logic sample_o,
	output logic done_o
);

	typedef enum logic [1:0] {
		SEQ_IDLE = 2'b00,
		SEQ_EMIT = 2'b01,
		SEQ_DONE = 2'b10
	} pmc_seq_state_type;

	pmc_seq_state_type state_q, state_d;
	logic [31:0] slot_q, slot_d, slot_len_q;
	logic [3:0] left_q, left_d;
	wire logic slot_end = (state_q == SEQ_EMIT) && (slot_q == 32'h00000001);
	wire logic last_pulse = (left_q == 4'h1);

	always_comb begin
		state_d = state_q;
		slot_d = slot_q;
		left_d = left_q;
		case (state_q)
			SEQ_IDLE: begin
				if (start_i) begin
					state_d = SEQ_EMIT;
					slot_d = slot_cycles_i;
					left_d = 4'h1 << pulse_code_i;
				end
			end
			SEQ_EMIT: begin
				if (slot_end) begin
					left_d = left_q - 4'h1;
					slot_d = slot_len_q;
					if (last_pulse) begin
						state_d = SEQ_DONE;
					end
				end else begin
					slot_d = slot_q - 32'h00000001;
				end
			end
			SEQ_DONE: begin
				state_d = SEQ_IDLE;
			end
			default: begin
				state_d = SEQ_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			state_q <= SEQ_IDLE;
			slot_q <= 32'h00000000;
			slot_len_q <= 32'h00000000;
			left_q <= 4'h0;
		end else begin
			state_q <= state_d;
			slot_q <= slot_d;
			left_q <= left_d;
			if (start_i && state_q == SEQ_IDLE) begin
				slot_len_q <= slot_cycles_i;
			end
		end
	end

	assign busy_o = (state_q != SEQ_IDLE);
	assign emit_o = (state_q == SEQ_EMIT);
	assign sample_o = slot_end;
	assign done_o = (state_q == SEQ_DONE);

endmodule // pmc_seq

// >>> pmc_top.sv
// pmc_top: proximity measurement configuration word, measurement timing and result limiting.
// assumes afe_count_i is produced by front end logic on mclk_i; registers sit on AHB-Lite.
// Operation
// - Bits 7:6 of the word at index 0x01 set the repeat period, code 2 meaning 200 ms.
// - Bits 5:4 set the integration time to 1, 2, 4 or 8 base pulses, 1 after reset.
// - Bits 3:2 set 1, 2, 4 or 8 emitter pulses per measurement, 1 after reset.
// - Bit 1 sets the base pulse to 25 us when clear (reset) and 50 us when set.
// - Bit 0 selects converter gain of one when clear (reset) and two when set.
// - Bit 13 selects normal sensitivity when clear (reset) and high when set.
// - Bit 12 enables crosstalk cancellation when set and is clear after reset.
// - With 12-bit resolution the result never exceeds 4095.
// - With 16-bit resolution and gain one the limit is 4095, 8191, 16383 or 32767 per multiplier.
// - With 16-bit resolution and gain two the limit is 8191, 16383, 32767 or 65535.
`timescale 1ns/1ns
module pmc_top
	import pmc_pkg::*;
#(
	parameter int CYC_PER_US = CLK_MHZ,
	parameter int CYC_PER_MS = CLK_MHZ * US_PER_MS,
	parameter int PERIOD_C0_MS = 50,
	parameter int PERIOD_C1_MS = 100,
	parameter int PERIOD_C3_MS = 400
) (
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic hready_i,
	input wire logic [31:0] hwdata_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o,
	input wire logic [15:0] afe_count_i,
	output logic emitter_on_o,
	output logic [2:0] emitter_drive_level_o,
	output logic converter_gain_o,
	output logic converter_sensitivity_o,
	output logic crosstalk_cancel_enable_o,
	output logic sample_o
);

	localparam int PERIOD_C2_CYC = PERIOD_C2_MS * CYC_PER_MS;
	localparam int SHORT_CYC = BASE_SHORT_US * CYC_PER_US;
	localparam int LONG_CYC = BASE_LONG_US * CYC_PER_US;

	function automatic logic [31:0] period_cycles(input logic [1:0] code);
		case (code)
			2'h0: return 32'(PERIOD_C0_MS * CYC_PER_MS);
			2'h1: return 32'(PERIOD_C1_MS * CYC_PER_MS);
			2'h2: return 32'(PERIOD_C2_CYC);
			default: return 32'(PERIOD_C3_MS * CYC_PER_MS);
		endcase
	endfunction

	// bus: zero wait states, config and control read data taken from next-state values so a
	// write immediately before a read of either of those words is not missed
	logic wr_ph_q;
	logic [5:0] wr_idx_q;
	logic [31:0] hrdata_q;
	pmc_cfg_type cfg_q, cfg_d, snap_q;
	pmc_ctrl_type ctrl_q, ctrl_d;
	logic wide_snap_q;
	logic [31:0] per_cnt_q;
	logic [19:0] acc_q;
	logic [15:0] result_q;
	logic new_q;

	wire logic addr_ph = hsel_i && hready_i && htrans_i[1];
	wire logic [5:0] addr_idx = haddr_i[7:2];
	wire logic wr_cfg = wr_ph_q && (wr_idx_q == CFG_IDX);
	wire logic wr_ctrl = wr_ph_q && (wr_idx_q == CTRL_IDX);
	wire logic wr_stat = wr_ph_q && (wr_idx_q == STATUS_IDX);
	wire logic new_clear = wr_stat && hwdata_i[STAT_NEW_BIT];

	// measurement sequencing
	logic seq_busy, seq_emit, seq_sample, seq_done;
	wire logic per_tick = ctrl_q.run_enable && (per_cnt_q == 32'h00000000);
	wire logic meas_start = per_tick && !seq_busy;
	wire logic [31:0] base_cyc = cfg_q.base_pulse_length ? 32'(LONG_CYC) : 32'(SHORT_CYC);
	wire logic [31:0] slot_cyc = base_cyc << cfg_q.integration_multiplier;
	wire logic [19:0] acc_sum = acc_q + 20'(afe_count_i);
	wire logic [15:0] lim = pmc_max_count(wide_snap_q, snap_q.converter_gain,
		snap_q.integration_multiplier);
	wire logic [15:0] sat = (acc_q > 20'(lim)) ? lim : acc_q[15:0];
	wire logic [31:0] status_word = {30'h00000000, new_q, seq_busy};

	assign cfg_d = wr_cfg ? pmc_cfg_type'(hwdata_i[15:0] & CFG_WRITE_MASK) : cfg_q;
	assign ctrl_d = wr_ctrl ? pmc_ctrl_type'(hwdata_i[1:0]) : ctrl_q;

	function automatic logic [31:0] read_word(input logic [5:0] idx, input pmc_cfg_type c,
			input pmc_ctrl_type k, input logic [15:0] r, input logic [31:0] s);
		case (idx)
			CFG_IDX: return {16'h0000, c};
			CTRL_IDX: return {30'h00000000, k};
			RESULT_IDX: return {16'h0000, r};
			STATUS_IDX: return s;
			default: return 32'h00000000;
		endcase
	endfunction

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			wr_ph_q <= 1'b0;
			wr_idx_q <= 6'h00;
			hrdata_q <= 32'h00000000;
		end else begin
			wr_ph_q <= addr_ph && hwrite_i;
			wr_idx_q <= addr_idx;
			if (addr_ph && !hwrite_i) begin
				hrdata_q <= read_word(addr_idx, cfg_d, ctrl_d, result_q, status_word);
			end
		end
	end

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			cfg_q <= pmc_cfg_type'(CFG_RESET);
			ctrl_q <= '0;
		end else begin
			cfg_q <= cfg_d;
			ctrl_q <= ctrl_d;
		end
	end

	// period counter reloads from the live word; the measurement itself runs
	// on a snapshot so mid-measurement writes do not disturb it
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			per_cnt_q <= 32'h00000000;
		end else if (!ctrl_q.run_enable) begin
			per_cnt_q <= 32'h00000000;
		end else if (per_tick) begin
			per_cnt_q <= period_cycles(cfg_q.repeat_period) - 32'h00000001;
		end else begin
			per_cnt_q <= per_cnt_q - 32'h00000001;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			snap_q <= pmc_cfg_type'(CFG_RESET);
			wide_snap_q <= 1'b0;
		end else if (meas_start) begin
			snap_q <= cfg_q;
			wide_snap_q <= ctrl_q.wide_resolution_select;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			acc_q <= 20'h00000;
			result_q <= 16'h0000;
			new_q <= 1'b0;
		end else begin
			if (meas_start) begin
				acc_q <= 20'h00000;
			end else if (seq_sample) begin
				acc_q <= acc_sum;
			end
			if (seq_done) begin
				result_q <= sat;
			end
			// a finishing measurement wins over a software clear
			new_q <= seq_done || (new_q && !new_clear);
		end
	end

	pmc_seq u_seq (
		.mclk_i(mclk_i),
		.rst_i(rst_i),
		.start_i(meas_start),
		.slot_cycles_i(slot_cyc),
		.pulse_code_i(cfg_q.pulse_count),
		.busy_o(seq_busy),
		.emit_o(seq_emit),
		.sample_o(seq_sample),
		.done_o(seq_done)
	);

	assign hrdata_o = hrdata_q;
	assign hreadyout_o = 1'b1;
	assign hresp_o = HRESP_OKAY;
	assign emitter_on_o = seq_emit;
	assign sample_o = seq_sample;
	// front end settings come from the snapshot
	assign emitter_drive_level_o = snap_q.emitter_drive_level;
	assign converter_gain_o = snap_q.converter_gain;
	assign converter_sensitivity_o = snap_q.converter_sensitivity;
	assign crosstalk_cancel_enable_o = snap_q.crosstalk_cancel_enable;

	// checks
	// the counters below only feed the assertions; they cost a few flops
	localparam int MAX_GAP = 8;
	logic [3:0] pulse_seen_q;
	logic [31:0] emit_len_q;
	always_ff @(posedge mclk_i) begin
		if (rst_i || meas_start) begin
			pulse_seen_q <= 4'h0;
		end else if (seq_sample) begin
			pulse_seen_q <= pulse_seen_q + 4'h1;
		end
		if (rst_i || !seq_emit || seq_sample) begin
			emit_len_q <= 32'h00000000;
		end else begin
			emit_len_q <= emit_len_q + 32'h00000001;
		end
	end

	sequence cfg_write_s;
		wr_cfg ##1 (cfg_q == pmc_cfg_type'($past(hwdata_i[15:0] & CFG_WRITE_MASK)));
	endsequence

	cfg_store_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		wr_cfg |-> cfg_write_s)
		else $error("config word not stored as written");

	cfg_reset_a: assert property (@(posedge mclk_i)
		rst_i |=> (cfg_q == pmc_cfg_type'(CFG_RESET)))
		else $error("config word not cleared by reset");

	period_200_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		(per_tick && cfg_q.repeat_period == PERIOD_C2_CODE) |=>
		(per_cnt_q == 32'(PERIOD_C2_CYC - 1)))
		else $error("200 ms period count wrong");

	slot_len_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		(seq_sample && pulse_seen_q == 4'h0) |->
		(emit_len_q + 32'h00000001 == ((snap_q.base_pulse_length ? 32'(LONG_CYC) :
		32'(SHORT_CYC)) << snap_q.integration_multiplier)))
		else $error("integration length wrong");

	pulse_count_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		seq_done |-> (pulse_seen_q == (4'h1 << snap_q.pulse_count)))
		else $error("emitter pulse count wrong");

	sequence start_s;
		meas_start ##1 (seq_emit && snap_q == $past(cfg_q));
	endsequence

	start_emit_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		meas_start |-> start_s)
		else $error("measurement did not start emitting");

	snap_hold_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		(seq_busy && $past(seq_busy) && !$past(meas_start)) |-> $stable(snap_q))
		else $error("settings changed during a measurement");

	narrow_lim_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		(seq_done && !wide_snap_q) |=> (result_q <= NARROW_MAX))
		else $error("12-bit result above 4095");

	wide_lim_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		(seq_done && wide_snap_q) |-> (lim == 16'(((32'h00001000) <<
		(3'(snap_q.integration_multiplier) + 3'(snap_q.converter_gain))) - 32'h00000001)))
		else $error("16-bit limit wrong");

	saturate_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		seq_done |=> (result_q == (($past(acc_q) > 20'($past(lim))) ? $past(lim) :
		$past(acc_q[15:0]))))
		else $error("result not saturated at the limit");

	drive_out_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		meas_start |=> (emitter_drive_level_o == $past(cfg_q.emitter_drive_level) &&
		converter_gain_o == $past(cfg_q.converter_gain)))
		else $error("front end settings not taken at measurement start");

	sens_xtalk_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		meas_start |=> (converter_sensitivity_o == $past(cfg_q.converter_sensitivity) &&
		crosstalk_cancel_enable_o == $past(cfg_q.crosstalk_cancel_enable)))
		else $error("sensitivity or crosstalk setting not applied");

	gain_out_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		meas_start |=> (converter_gain_o == $past(cfg_q.converter_gain)) ##[1:MAX_GAP] seq_emit)
		else $error("gain not applied at measurement start");

	result_new_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		seq_done |=> (new_q && result_q <= $past(lim)))
		else $error("result above limit or new flag not set");

	wide_top_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		(seq_done && wide_snap_q && snap_q.converter_gain && (&snap_q.integration_multiplier))
		|-> (lim == '1))
		else $error("top wide limit not full scale");

	sequence finish_s;
		seq_done ##1 (!seq_busy && !seq_done && !seq_emit);
	endsequence

	done_end_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		seq_done |-> finish_s)
		else $error("measurement did not end after its last pulse");

	rsv_zero_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		(cfg_q.rsv_hi == 2'h0) && !cfg_q.rsv_mid)
		else $error("reserved config bits not zero");

	run_off_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		!ctrl_q.run_enable |-> !meas_start)
		else $error("measurement started while stopped");

endmodule // pmc_top

// >>> pmc_top_tb_top.sv
// pmc_top_tb_top: self-checking bench for the proximity measurement configuration block.
// assumes one AHB-Lite slave, time scaled down by CYC_PER_US=1 and CYC_PER_MS=50.
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin \
	cmp_count++; \
	if ((ex) !== (got)) begin \
		err_total++; \
		$display("wrong value %s exp %h got %h", nm, ex, got); \
	end \
end
module pmc_top_tb_top;
	import pmc_pkg::*;
	localparam int MS = 50;
	// short periods for the free codes keep the run brief; code 2 is fixed
	localparam int P0_MS = 20;
	localparam int P1_MS = 40;
	localparam int P3_MS = 80;
	logic mclk_i = 1'b0;
	logic rst_i = 1'b1;
	logic hsel_i = 1'b0;
	logic [31:0] haddr_i = 32'h0;
	logic [1:0] htrans_i = 2'h0;
	logic hwrite_i = 1'b0;
	logic [2:0] hsize_i = 3'h2;
	logic [31:0] hwdata_i = 32'h0;
	logic [15:0] afe_count_i = 16'h0;
	logic [31:0] hrdata_o;
	logic hreadyout_o, hresp_o, emitter_on_o, converter_gain_o, converter_sensitivity_o;
	logic crosstalk_cancel_enable_o, sample_o;
	logic [2:0] emitter_drive_level_o;
	logic [31:0] rd;
	int err_total = 0;
	int cmp_count = 0;
	int on_cnt = 0;
	int smp_cnt = 0;
	int cyc = 0;

	always #4 mclk_i = ~mclk_i;

	// pre-update values at the edge, so counts match the cycles the pin was high
	always @(posedge mclk_i) begin
		cyc++;
		if (emitter_on_o === 1'b1) on_cnt++;
		if (sample_o === 1'b1) smp_cnt++;
	end

	pmc_top #(.CYC_PER_US(1), .CYC_PER_MS(MS), .PERIOD_C0_MS(P0_MS), .PERIOD_C1_MS(P1_MS),
		.PERIOD_C3_MS(P3_MS)) u_dut (
		.mclk_i(mclk_i), .rst_i(rst_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
		.htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hready_i(hreadyout_o),
		.hwdata_i(hwdata_i), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
		.afe_count_i(afe_count_i), .emitter_on_o(emitter_on_o),
		.emitter_drive_level_o(emitter_drive_level_o), .converter_gain_o(converter_gain_o),
		.converter_sensitivity_o(converter_sensitivity_o),
		.crosstalk_cancel_enable_o(crosstalk_cancel_enable_o), .sample_o(sample_o)
	);

	task automatic test_done();
		$display("comparisons %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// one single word transfer; read data lands in rd
	task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
		@(posedge mclk_i);
		hsel_i <= 1'b1;
		haddr_i <= a;
		htrans_i <= HTRANS_NONSEQ;
		hwrite_i <= wr;
		@(posedge mclk_i);
		while (hreadyout_o !== 1'b1) @(posedge mclk_i);
		htrans_i <= 2'h0;
		hwdata_i <= d;
		@(posedge mclk_i);
		while (hreadyout_o !== 1'b1) @(posedge mclk_i);
		rd = hrdata_o;
		`CHK("hresp", HRESP_OKAY, hresp_o)
	endtask

	task automatic wait_on(input logic lvl);
		int n;
		n = 0;
		@(negedge mclk_i);
		while (emitter_on_o !== lvl && n < 12000) begin
			@(negedge mclk_i);
			n++;
		end
		`CHK("emitter level", lvl, emitter_on_o)
	endtask

	// one measurement, expectations worked out from the word written
	task automatic run_meas(input logic [15:0] cfg, input logic wide, input logic [15:0] afe,
			input logic mid);
		logic [31:0] lim, sum, on_exp;
		afe_count_i <= afe;
		on_cnt = 0;
		smp_cnt = 0;
		bus(1'b1, 32'h04, {16'h0, cfg});
		bus(1'b1, 32'h10, {30'h0, wide, 1'b1});
		wait_on(1'b1);
		if (mid) bus(1'b1, 32'h04, {16'h0, cfg ^ 16'h0033});
		wait_on(1'b0);
		repeat (4) @(posedge mclk_i);
		bus(1'b1, 32'h10, 32'h0);
		on_exp = (cfg[1] ? BASE_LONG_US : BASE_SHORT_US) << (32'(cfg[5:4]) + 32'(cfg[3:2]));
		sum = 32'(afe) << cfg[3:2];
		lim = wide ? ((32'h1000 << (32'(cfg[5:4]) + 32'(cfg[0]))) - 32'h1) : 32'hfff;
		`CHK("emitter cycles", on_exp, on_cnt)
		`CHK("sample pulses", 32'h1 << cfg[3:2], smp_cnt)
		`CHK("gain", cfg[0], converter_gain_o)
		`CHK("sensitivity", cfg[13], converter_sensitivity_o)
		`CHK("crosstalk", cfg[12], crosstalk_cancel_enable_o)
		`CHK("drive", cfg[10:8], emitter_drive_level_o)
		bus(1'b0, 32'h14, 32'h0);
		`CHK("result", (sum > lim) ? lim : sum, rd)
		bus(1'b0, 32'h18, 32'h0);
		`CHK("status after run", 32'h2, rd)
		bus(1'b1, 32'h18, 32'h2);
		bus(1'b0, 32'h18, 32'h0);
		`CHK("status cleared", 32'h0, rd)
		if (mid) begin
			bus(1'b0, 32'h04, 32'h0);
			`CHK("cfg after change", {16'h0, cfg ^ 16'h0033}, rd)
		end
	endtask

	task automatic t_reset();
		logic [31:0] adr [5];
		adr = '{32'h04, 32'h10, 32'h14, 32'h18, 32'h3c};
		foreach (adr[i]) begin
			bus(1'b0, adr[i], 32'h0);
			`CHK("reset read", 32'h0, rd)
		end
		`CHK("reset drive", 3'h0, emitter_drive_level_o)
		`CHK("reset gain", 1'b0, converter_gain_o)
		`CHK("reset sens", 1'b0, converter_sensitivity_o)
		`CHK("reset xtalk", 1'b0, crosstalk_cancel_enable_o)
		$display("test reset done");
	endtask

	task automatic t_regs();
		bus(1'b1, 32'h04, 32'h37ff);
		bus(1'b0, 32'h04, 32'h0);
		`CHK("cfg readback", 32'h37ff, rd)
		bus(1'b1, 32'h3c, 32'hffffffff);
		bus(1'b0, 32'h3c, 32'h0);
		`CHK("unmapped read", 32'h0, rd)
		bus(1'b1, 32'h04, 32'h0);
		$display("test registers done");
	endtask

	// every drive code, with gain, sensitivity and crosstalk toggled alongside
	task automatic t_fields();
		logic [2:0] c;
		for (int i = 0; i < 8; i++) begin
			c = 3'(i);
			run_meas({2'h0, c[0], c[1], 1'b0, c, 7'h00, c[2]}, 1'b0,
				c[0] ? 16'hffff : 16'h0123, 1'b0);
		end
		$display("test fields done");
	endtask

	// all multipliers under both gains at full input, wide resolution
	task automatic t_limits();
		logic [1:0] k;
		for (int g = 0; g < 2; g++) begin
			for (int i = 0; i < 4; i++) begin
				k = 2'(i);
				run_meas({10'h000, k, 2'(3 - i), k[0], 1'(g)}, 1'b1, 16'hffff,
					1'b0);
			end
		end
		$display("test limits done");
	endtask

	task automatic t_mid();
		run_meas(16'h0011, 1'b1, 16'h1800, 1'b1);
		$display("test mid change done");
	endtask

	// every period code, start to start of two measurements
	task automatic t_period();
		int t0;
		int exp_ms [4];
		exp_ms = '{P0_MS, P1_MS, PERIOD_C2_MS, P3_MS};
		for (int p = 0; p < 4; p++) begin
			bus(1'b1, 32'h04, {24'h0, 2'(p), 6'h00});
			bus(1'b1, 32'h10, 32'h1);
			wait_on(1'b1);
			t0 = cyc;
			wait_on(1'b0);
			wait_on(1'b1);
			`CHK("period cycles", exp_ms[p] * MS, cyc - t0)
			bus(1'b1, 32'h10, 32'h0);
			wait_on(1'b0);
		end
		$display("test period done");
	endtask

	initial begin
		repeat (40000) @(posedge mclk_i);
		err_total++;
		$display("watchdog expired");
		test_done();
	end

	initial begin
		repeat (16) @(posedge mclk_i);
		rst_i <= 1'b0;
		t_reset();
		t_regs();
		t_fields();
		t_limits();
		t_mid();
		t_period();
		test_done();
	end
endmodule // pmc_top_tb_top
